// ===== cable_model.sv
// Cable model: echoes each driven pulse back on the pair it was sent on.
// Assumes the tester's driver outputs and one shared clock.
`timescale 1ns/100ps
`default_nettype none
module cable_model #(parameter int DELAY = 10, parameter logic [7:0] AMP = 8'h32)
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       ten_level,
  input  wire logic       ten_rx,
  input  wire logic [1:0] sym,
  input  wire logic       sym_rx,
  output logic      [7:0] tx_sample,
  output logic      [7:0] rx_sample
);
  logic [31:0] tx_line;
  logic [31:0] rx_line;
  logic [31:0] neg_line;
  logic        toggle;
  logic [7:0]  base;
  logic [7:0]  echo;
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_line  <= 32'h0;
      rx_line  <= 32'h0;
      neg_line <= 32'h0;
      toggle   <= 1'b0;
    end
    else
    begin
      tx_line  <= {tx_line[30:0], (ten_level && !ten_rx) || (sym != 2'h0 && !sym_rx)};
      rx_line  <= {rx_line[30:0], (ten_level && ten_rx) || (sym != 2'h0 && sym_rx)};
      neg_line <= {neg_line[30:0], sym == 2'h3};
      toggle   <= !toggle;
    end
  end
  // A quiet pair still shows converter noise that changes every cycle.
  assign base      = toggle ? 8'h01 : 8'hFF;
  assign echo      = neg_line[DELAY] ? -AMP : AMP;
  assign tx_sample = tx_line[DELAY] ? echo : base;
  assign rx_sample = rx_line[DELAY] ? echo : base;
endmodule // cable_model
`default_nettype wire

// ===== cable_reflectometry_tester.v
// Cable reflectometry tester: diagnostics page registers, line driver
// takeover, test pulse launch and echo capture on the selected pair.
// Assumes the management port and converter samples share the clock; the
// page select register lives outside and is presented on its own port.
//
// Overview of operation
// - Control sits at 16h, window at 17h, on the diagnostics page.
// - Enable bit 15 hands both line drivers to the test logic.
// - Writing bit 11 with bit 15 set and no capture running sends one pulse and starts the monitor together.
// - Bit 14 picks ten-megabit link pulses or hundred-megabit data pulses.
// - Bits 10:8 give hundred-megabit width of 0 to 7 clocks; ten-megabit uses 2 clocks for 1 to 3, 3 clocks for 4 to 7.
// - A zero width sends no pulse on either pair.
// - Bit 13 set sends the pulse on the receive pair, else transmit pair.
// - Bit 12 set monitors the receive pair, else the transmit pair.
// - Bit 7 picks maximum positive or minimum negative tracking.
// - Window start is bits 15:8, stop bits 7:0; outside samples ignored.
// - After reset window start reads 0 and stop reads 255.
// - Ticks are clock steps; the window spans 256 ticks.
// - Monitor tracks the extreme peak and a programmable threshold crossing.
// - Both results keep the tick of first occurrence; equal values ignored.
// - Peak result is read-only at 18h, threshold result at 19h.
// - Ten-megabit mode emits 80 ns or 120 ns link pulses, 50 ns and 100 ns rounded up to clocks.
// - Hundred-megabit pulses alternate positive and negative.
// - A zero width still runs the monitor to capture a baseline.
// - The tick timer starts one clock before the pulse reaches the registered line driver outputs.
`timescale 1ns/100ps
`default_nettype none
`include "reflectometry_map.vh"

module cable_reflectometry_tester
(
  input  wire        clock,
  input  wire        rst_n,
  input  wire [2:0]  register_page_select,
  input  wire [4:0]  mgmt_addr,
  input  wire        mgmt_write,
  input  wire [15:0] mgmt_wdata,
  input  wire        normal_ten_level,
  input  wire [1:0]  normal_hundred_sym,
  input  wire [7:0]  adc_tx_pair_sample,
  input  wire [7:0]  adc_rx_pair_sample,
  output reg  [15:0] mgmt_rdata,
  output reg         test_owns_drivers,
  output reg         ten_meg_line_driver_level,
  output reg         ten_meg_line_driver_rx_pair,
  output reg  [1:0]  hundred_meg_line_driver_sym,
  output reg         hundred_meg_line_driver_rx_pair
);

  // Stored control bits; bit 11 is not stored here, it reads back as busy.
  reg  [15:0] pulse_test_control_reg;
  reg  [15:0] pulse_test_control_next;
  reg  [15:0] echo_window_reg;
  reg  [15:0] echo_window_next;
  reg         busy_reg;
  reg         busy_next;
  reg         start_reg;
  reg         start_next;
  reg  [15:0] rdata_next;
  reg  [7:0]  sample_reg;

  wire        ctl_write;
  wire        win_write;
  wire        enabled;
  wire        gen_ten_level;
  wire [1:0]  gen_hundred_sym;
  wire        mon_done;
  wire [7:0]  peak_value;
  wire [7:0]  peak_tick;
  wire        thr_hit;
  wire [7:0]  thr_tick;
  wire [15:0] peak_result;
  wire [15:0] thr_result;
  wire [15:0] control_view;

  // Register decode on the diagnostics page, shared by reads and writes.
  function diag_hit;
    input [2:0] page;
    input [4:0] addr;
    input [4:0] want;
    begin
      diag_hit = (page == `DIAG_PAGE) && (addr == want);
    end
  endfunction

  assign ctl_write = mgmt_write &&
                     diag_hit(register_page_select, mgmt_addr,
                              `OFS_PULSE_TEST_CONTROL);
  assign win_write = mgmt_write &&
                     diag_hit(register_page_select, mgmt_addr,
                              `OFS_ECHO_WINDOW);

  assign enabled = pulse_test_control_reg[`CTL_ENABLE_BIT];

  // Control register and the send request.
  always @*
  begin
    pulse_test_control_next = pulse_test_control_reg;
    start_next              = 1'b0;
    if (ctl_write)
    begin
      pulse_test_control_next = mgmt_wdata;
      pulse_test_control_next[`CTL_SEND_BIT] = 1'b0;
      // A send while a capture runs is dropped so results stay coherent.
      if (mgmt_wdata[`CTL_SEND_BIT] && mgmt_wdata[`CTL_ENABLE_BIT] &&
          !busy_reg)
        start_next = 1'b1;
    end
  end

  // Busy flag: the send sets it, the end of the window clears it.
  // The set wins when both fall on the same cycle.
  always @*
  begin
    busy_next = busy_reg;
    if (mon_done)
      busy_next = 1'b0;
    if (start_next)
      busy_next = 1'b1;
  end

  always @*
  begin
    echo_window_next = echo_window_reg;
    if (win_write)
      echo_window_next = mgmt_wdata;
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulse_test_control_reg <= `CTL_RESET;
      echo_window_reg        <= `WIN_RESET;
      busy_reg               <= 1'b0;
      start_reg              <= 1'b0;
    end
    else
    begin
      pulse_test_control_reg <= pulse_test_control_next;
      echo_window_reg        <= echo_window_next;
      busy_reg               <= busy_next;
      start_reg              <= start_next;
    end
  end

  // Pulse generator and monitor share one start strobe, so the tick
  // timer counts from the launch of the pulse.
  test_pulse_generator pulse_gen
  (
    .clock       (clock),
    .rst_n       (rst_n),
    .start       (start_reg),
    .use_hundred (pulse_test_control_reg[`CTL_HUNDRED_BIT]),
    .width       (pulse_test_control_reg[`CTL_WIDTH_HI:`CTL_WIDTH_LO]),
    .ten_level   (gen_ten_level),
    .hundred_sym (gen_hundred_sym)
  );

  // Pair selection for the monitor input; registered to align with ticks.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sample_reg <= 8'h00;
    else if (pulse_test_control_reg[`CTL_MON_RX_PAIR_BIT])
      sample_reg <= adc_rx_pair_sample;
    else
      sample_reg <= adc_tx_pair_sample;
  end

  // The monitor runs even with a zero width, giving a baseline capture.
  echo_monitor monitor
  (
    .clock      (clock),
    .rst_n      (rst_n),
    .start      (start_reg),
    .min_mode   (pulse_test_control_reg[`CTL_MIN_MODE_BIT]),
    .sample     (sample_reg),
    .win_start  (echo_window_reg[`WIN_START_HI:`WIN_START_LO]),
    .win_stop   (echo_window_reg[`WIN_STOP_HI:`WIN_STOP_LO]),
    .threshold  (pulse_test_control_reg[`CTL_THRESH_HI:`CTL_THRESH_LO]),
    .busy       (),
    .done       (mon_done),
    .peak_value (peak_value),
    .peak_tick  (peak_tick),
    .thr_hit    (thr_hit),
    .thr_tick   (thr_tick)
  );

  assign peak_result  = {peak_tick, peak_value};
  assign thr_result   = {thr_hit, 7'h00, thr_tick};
  assign control_view = {pulse_test_control_reg[15:12], busy_reg,
                         pulse_test_control_reg[10:0]};

  // Read data is registered; an unmapped offset or another page reads zero.
  always @*
  begin
    rdata_next = 16'h0000;
    if (diag_hit(register_page_select, mgmt_addr, `OFS_PULSE_TEST_CONTROL))
      rdata_next = control_view;
    else if (diag_hit(register_page_select, mgmt_addr, `OFS_ECHO_WINDOW))
      rdata_next = echo_window_reg;
    else if (diag_hit(register_page_select, mgmt_addr, `OFS_ECHO_PEAK_RESULT))
      rdata_next = peak_result;
    else if (diag_hit(register_page_select, mgmt_addr, `OFS_ECHO_THR_RESULT))
      rdata_next = thr_result;
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mgmt_rdata <= 16'h0000;
    else
      mgmt_rdata <= rdata_next;
  end

  // Driver takeover. Outputs are registered so the drivers never see a
  // glitch while ownership changes hands.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      test_owns_drivers               <= 1'b0;
      ten_meg_line_driver_level       <= 1'b0;
      ten_meg_line_driver_rx_pair     <= 1'b0;
      hundred_meg_line_driver_sym     <= `SYM_IDLE;
      hundred_meg_line_driver_rx_pair <= 1'b0;
    end
    else if (enabled)
    begin
      test_owns_drivers               <= 1'b1;
      ten_meg_line_driver_level       <= gen_ten_level;
      hundred_meg_line_driver_sym     <= gen_hundred_sym;
      ten_meg_line_driver_rx_pair     <=
        pulse_test_control_reg[`CTL_TX_RX_PAIR_BIT];
      hundred_meg_line_driver_rx_pair <=
        pulse_test_control_reg[`CTL_TX_RX_PAIR_BIT];
    end
    else
    begin
      test_owns_drivers               <= 1'b0;
      ten_meg_line_driver_level       <= normal_ten_level;
      hundred_meg_line_driver_sym     <= normal_hundred_sym;
      ten_meg_line_driver_rx_pair     <= 1'b0;
      hundred_meg_line_driver_rx_pair <= 1'b0;
    end
  end

endmodule // cable_reflectometry_tester
`default_nettype wire

// ===== echo_monitor.v
// Echo monitor: tick timer, window qualification, peak and threshold capture.
// Assumes samples are signed converter words on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "reflectometry_map.vh"

module echo_monitor
(
  input  wire       clock,
  input  wire       rst_n,
  input  wire       start,
  input  wire       min_mode,
  input  wire [7:0] sample,
  input  wire [7:0] win_start,
  input  wire [7:0] win_stop,
  input  wire [6:0] threshold,
  output reg        busy,
  output reg        done,
  output reg  [7:0] peak_value,
  output reg  [7:0] peak_tick,
  output reg        thr_hit,
  output reg  [7:0] thr_tick
);

  reg  [7:0] tick_reg;
  reg        peak_seen_reg;
  wire       in_window;
  wire       better;
  wire       crossed;
  wire [7:0] thr_pos;
  wire [7:0] thr_neg;

  assign in_window = (tick_reg >= win_start) && (tick_reg <= win_stop);
  // Strict comparison: a later equal sample keeps the earlier time.
  assign better    = min_mode ? ($signed(sample) < $signed(peak_value))
                              : ($signed(sample) > $signed(peak_value));
  assign thr_pos   = {1'b0, threshold};
  assign thr_neg   = 8'h00 - thr_pos;
  assign crossed   = min_mode ? ($signed(sample) < $signed(thr_neg))
                              : ($signed(sample) > $signed(thr_pos));

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_reg      <= 8'h00;
      peak_seen_reg <= 1'b0;
      busy          <= 1'b0;
      done          <= 1'b0;
      peak_value    <= 8'h00;
      peak_tick     <= 8'h00;
      thr_hit       <= 1'b0;
      thr_tick      <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        busy          <= 1'b1;
        tick_reg      <= 8'h00;
        peak_seen_reg <= 1'b0;
        peak_value    <= 8'h00;
        peak_tick     <= 8'h00;
        thr_hit       <= 1'b0;
        thr_tick      <= 8'h00;
      end
      else if (busy)
      begin
        if (in_window)
        begin
          if (!peak_seen_reg || better)
          begin
            peak_seen_reg <= 1'b1;
            peak_value    <= sample;
            peak_tick     <= tick_reg;
          end
          if (!thr_hit && crossed)
          begin
            thr_hit  <= 1'b1;
            thr_tick <= tick_reg;
          end
        end
        if (tick_reg == `TICK_LAST)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        tick_reg <= tick_reg + 8'h01;
      end
    end
  end

endmodule // echo_monitor
`default_nettype wire

// ===== reflectometry_checker.sv
// Checker for the cable reflectometry tester, bound to its top module.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "reflectometry_map.vh"
module reflectometry_checker
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [2:0]  register_page_select,
  input wire logic [4:0]  mgmt_addr,
  input wire logic        mgmt_write,
  input wire logic [15:0] mgmt_wdata,
  input wire logic        normal_ten_level,
  input wire logic [1:0]  normal_hundred_sym,
  input wire logic [15:0] mgmt_rdata,
  input wire logic        test_owns_drivers,
  input wire logic        ten_meg_line_driver_level,
  input wire logic        ten_meg_line_driver_rx_pair,
  input wire logic [1:0]  hundred_meg_line_driver_sym,
  input wire logic        hundred_meg_line_driver_rx_pair
);
  logic [8:0] quiet_cnt;
  logic [1:0] last_sym;
  logic       diag;
  logic       ctl_wr;
  logic       send_ok;
  assign diag = register_page_select == `DIAG_PAGE;
  assign ctl_wr = mgmt_write && diag && mgmt_addr == `OFS_PULSE_TEST_CONTROL;
  // The count outlasts a capture so a refused send is never taken for a launch.
  assign send_ok = ctl_wr && mgmt_wdata[15] && mgmt_wdata[11] && quiet_cnt == 9'h000;
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quiet_cnt <= 9'h000;
      last_sym  <= `SYM_IDLE;
    end
    else
    begin
      quiet_cnt <= send_ok ? 9'h12C : (quiet_cnt != 9'h000 ? quiet_cnt - 9'h001 : 9'h000);
      if (test_owns_drivers && hundred_meg_line_driver_sym != `SYM_IDLE)
        last_sym <= hundred_meg_line_driver_sym;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence short_pulse;
    ten_meg_line_driver_level [*2] ##1 !ten_meg_line_driver_level;
  endsequence
  sequence long_pulse;
    ten_meg_line_driver_level [*3] ##1 !ten_meg_line_driver_level;
  endsequence
  a_short_link_pulse: assert property (send_ok && !mgmt_wdata[14] && !mgmt_wdata[10]
    && mgmt_wdata[9:8] != 2'h0 |-> ##1 !ten_meg_line_driver_level [*2] ##1 short_pulse)
    else $error("short link pulse wrong");
  a_long_link_pulse: assert property (send_ok && !mgmt_wdata[14] && mgmt_wdata[10]
    |-> ##3 long_pulse) else $error("long link pulse wrong");
  a_zero_width_quiet: assert property (send_ok && mgmt_wdata[10:8] == 3'h0 |=>
    (!ten_meg_line_driver_level && hundred_meg_line_driver_sym == `SYM_IDLE) [*8])
    else $error("pulse sent with zero width");
  a_hundred_launch: assert property (send_ok && mgmt_wdata[14] && mgmt_wdata[10:8] != 3'h0
    |-> ##3 hundred_meg_line_driver_sym != `SYM_IDLE) else $error("data pulse missing");
  a_sym_alternate: assert property (test_owns_drivers && $past(hundred_meg_line_driver_sym)
    == `SYM_IDLE && hundred_meg_line_driver_sym != `SYM_IDLE
    |-> hundred_meg_line_driver_sym != last_sym) else $error("polarity repeated");
  a_owns_follow: assert property (ctl_wr |-> ##2
    test_owns_drivers == $past(mgmt_wdata[15], 2)) else $error("driver ownership wrong");
  a_normal_pass: assert property (!test_owns_drivers && $past(!test_owns_drivers)
    |-> ten_meg_line_driver_level == $past(normal_ten_level)
    && hundred_meg_line_driver_sym == $past(normal_hundred_sym)) else $error("normal path lost");
  a_rx_pair_idle: assert property (!test_owns_drivers |-> !ten_meg_line_driver_rx_pair
    && !hundred_meg_line_driver_rx_pair) else $error("pair select while disabled");
  a_unmapped_zero: assert property (!diag || mgmt_addr < 5'h16 || mgmt_addr > 5'h19
    |=> mgmt_rdata == 16'h0000) else $error("unmapped read not zero");
  a_thr_format: assert property (diag && mgmt_addr == `OFS_ECHO_THR_RESULT
    |=> mgmt_rdata[14:8] == 7'h00) else $error("threshold result reserved bits set");
endmodule // reflectometry_checker
bind cable_reflectometry_tester reflectometry_checker reflectometry_checker_inst (.clock,
  .rst_n, .register_page_select, .mgmt_addr, .mgmt_write, .mgmt_wdata, .normal_ten_level,
  .normal_hundred_sym, .mgmt_rdata, .test_owns_drivers, .ten_meg_line_driver_level,
  .ten_meg_line_driver_rx_pair, .hundred_meg_line_driver_sym, .hundred_meg_line_driver_rx_pair);
`default_nettype wire

// ===== reflectometry_map.vh
// Register offsets, field positions, reset values and timing counts of the
// cable reflectometry tester. Definitions only; included by every design file.
`ifndef REFLECTOMETRY_MAP_VH
`define REFLECTOMETRY_MAP_VH

// Page that holds the link diagnostics registers.
`define DIAG_PAGE              3'h2

// Register offsets within the diagnostics page.
`define OFS_PULSE_TEST_CONTROL 5'h16
`define OFS_ECHO_WINDOW        5'h17
`define OFS_ECHO_PEAK_RESULT   5'h18
`define OFS_ECHO_THR_RESULT    5'h19

// Pulse-test control fields.
`define CTL_ENABLE_BIT         15
`define CTL_HUNDRED_BIT        14
`define CTL_TX_RX_PAIR_BIT     13
`define CTL_MON_RX_PAIR_BIT    12
`define CTL_SEND_BIT           11
`define CTL_WIDTH_HI           10
`define CTL_WIDTH_LO           8
`define CTL_MIN_MODE_BIT       7
`define CTL_THRESH_HI          6
`define CTL_THRESH_LO          0

// Echo window fields.
`define WIN_START_HI           15
`define WIN_START_LO           8
`define WIN_STOP_HI            7
`define WIN_STOP_LO            0

// Reset values.
`define CTL_RESET              16'h0000
`define WIN_RESET              16'h00FF

// Timing.
`define CLK_PERIOD_NS          40
`define TICK_NS                8
`define WINDOW_NS              2048
`define WINDOW_TICKS           (`WINDOW_NS / `TICK_NS)
`define TICK_LAST              8'hFF
`define TEN_SHORT_NS           50
`define TEN_LONG_NS            100
`define TEN_SHORT_CYCLES       ((`TEN_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TEN_LONG_CYCLES        ((`TEN_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TEN_LONG_MIN_WIDTH     3'h4

// Hundred-megabit driver symbols.
`define SYM_IDLE               2'h0
`define SYM_POS                2'h1
`define SYM_NEG                2'h3

`endif

// ===== tb_top.sv
// Self-checking bench for the cable reflectometry tester and a cable model.
// Assumes the management port and converter samples share the one clock.
`timescale 1ns/100ps
`default_nettype none
`include "reflectometry_map.vh"
module tb_top;
  localparam logic [7:0] ECHO_TICK = 8'h0D;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  page  = `DIAG_PAGE;
  logic [4:0]  addr  = 5'h00;
  logic        wr    = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic        n_ten = 1'b0;
  logic [1:0]  n_sym = 2'h0;
  logic [7:0]  tx_s;
  logic [7:0]  rx_s;
  logic [15:0] rdata;
  logic        owns;
  logic        ten_lvl;
  logic        ten_rx;
  logic [1:0]  sym;
  logic        sym_rx;
  logic [15:0] val;
  logic [1:0]  fs;
  int          pc;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  cable_reflectometry_tester cable_reflectometry_tester_inst (.clock(clock), .rst_n(rst_n),
    .register_page_select(page), .mgmt_addr(addr), .mgmt_write(wr), .mgmt_wdata(wdata),
    .normal_ten_level(n_ten), .normal_hundred_sym(n_sym), .adc_tx_pair_sample(tx_s),
    .adc_rx_pair_sample(rx_s), .mgmt_rdata(rdata), .test_owns_drivers(owns),
    .ten_meg_line_driver_level(ten_lvl), .ten_meg_line_driver_rx_pair(ten_rx),
    .hundred_meg_line_driver_sym(sym), .hundred_meg_line_driver_rx_pair(sym_rx));
  cable_model cable_model_inst (.clock(clock), .rst_n(rst_n), .ten_level(ten_lvl),
    .ten_rx(ten_rx), .sym(sym), .sym_rx(sym_rx), .tx_sample(tx_s), .rx_sample(rx_s));
  always #20 clock = ~clock;
  task automatic finish_test;
  begin
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask
  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
  begin
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  end
  endtask
  task automatic reg_read(input logic [4:0] a, output logic [15:0] d);
  begin
    @(posedge clock);
    addr <= a;
    @(posedge clock);
    @(posedge clock);
    #1 d = rdata;
  end
  endtask
  // Polls busy through the control register, counting cycles with a driver active.
  task automatic run(input logic [15:0] ctl);
    int i;
  begin
    pc = 0;
    fs = `SYM_IDLE;
    reg_write(`OFS_PULSE_TEST_CONTROL, ctl);
    for (i = 0; i < 400; i++)
    begin
      @(posedge clock);
      #1;
      if (ten_lvl || sym != `SYM_IDLE)
        pc++;
      if (fs == `SYM_IDLE)
        fs = sym;
      if (i == 2)
        chk({15'h0, rdata[11]}, 16'h0001, "busy");
      if (i > 4 && !rdata[11])
        break;
    end
    if (i == 400)
      chk(16'h0001, 16'h0000, "capture never ended");
    repeat (60) @(posedge clock);
  end
  endtask
  task automatic results(input logic [15:0] peak, input logic [15:0] thr);
  begin
    reg_read(`OFS_ECHO_PEAK_RESULT, val);
    chk(val, peak, "peak result");
    reg_read(`OFS_ECHO_THR_RESULT, val);
    chk(val, thr, "threshold result");
  end
  endtask
  task automatic t_reset;
  begin
    reg_read(`OFS_ECHO_WINDOW, val);
    chk(val, `WIN_RESET, "window reset");
    reg_read(`OFS_PULSE_TEST_CONTROL, val);
    chk(val, `CTL_RESET, "control reset");
    reg_read(5'h1A, val);
    chk(val, 16'h0000, "unmapped");
    @(posedge clock);
    page <= 3'h0;
    reg_write(`OFS_PULSE_TEST_CONTROL, 16'h8000);
    reg_read(`OFS_ECHO_WINDOW, val);
    chk(val, 16'h0000, "other page read");
    @(posedge clock);
    page <= `DIAG_PAGE;
    reg_read(`OFS_PULSE_TEST_CONTROL, val);
    chk(val, `CTL_RESET, "other page write");
  end
  endtask
  task automatic t_link;
  begin
    run(16'h8A14);
    chk(pc[15:0], 16'h0002, "short link pulse");
    results({ECHO_TICK, 8'h32}, {8'h80, ECHO_TICK});
    run(16'h8D14);
    chk(pc[15:0], 16'h0003, "long link pulse");
  end
  endtask
  task automatic t_hundred;
  begin
    run(16'hFB94);
    chk({14'h0, fs}, {14'h0, `SYM_POS}, "first polarity");
    chk(pc[15:0], 16'h0003, "data pulse width");
    run(16'hFB94);
    chk({14'h0, fs}, {14'h0, `SYM_NEG}, "second polarity");
    results({ECHO_TICK, 8'hCE}, {8'h80, ECHO_TICK});
    run(16'h9A14);
    results({8'h00, 8'h01}, 16'h0000);
  end
  endtask
  task automatic t_window;
  begin
    // Starting past the first echo tick hides it, as software does with its own pulse.
    reg_write(`OFS_ECHO_WINDOW, 16'h0EFF);
    run(16'h8A14);
    results({8'h0E, 8'h32}, {8'h80, 8'h0E});
    reg_write(`OFS_ECHO_WINDOW, 16'h000C);
    run(16'h8A14);
    reg_read(`OFS_ECHO_THR_RESULT, val);
    chk(val, 16'h0000, "stop tick");
    reg_write(`OFS_ECHO_WINDOW, `WIN_RESET);
    reg_read(`OFS_ECHO_WINDOW, val);
    chk(val, `WIN_RESET, "window readback");
  end
  endtask
  task automatic t_zero;
    logic [15:0] keep;
  begin
    run(16'h8814);
    chk(pc[15:0], 16'h0000, "zero width");
    reg_read(`OFS_ECHO_PEAK_RESULT, keep);
    reg_write(`OFS_ECHO_PEAK_RESULT, 16'hFFFF);
    reg_read(`OFS_ECHO_PEAK_RESULT, val);
    chk(val, keep, "read-only peak");
  end
  endtask
  task automatic t_handback;
  begin
    @(posedge clock);
    n_ten <= 1'b1;
    n_sym <= `SYM_POS;
    reg_write(`OFS_PULSE_TEST_CONTROL, 16'hA000);
    repeat (2) @(posedge clock);
    #1 chk({10'h0, owns, ten_rx, sym_rx, ten_lvl, sym}, 16'h0038, "takeover");
    reg_write(`OFS_PULSE_TEST_CONTROL, 16'h0000);
    repeat (2) @(posedge clock);
    #1 chk({10'h0, owns, ten_rx, sym_rx, ten_lvl, sym}, 16'h0005, "handback");
    @(posedge clock);
    n_ten <= 1'b0;
    n_sym <= `SYM_IDLE;
  end
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_link();
    t_hundred();
    t_window();
    t_zero();
    t_handback();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire

// ===== test_pulse_generator.v
// Test pulse generator: one pulse per start with a nonzero width, shaped for the selected driver.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "reflectometry_map.vh"

module test_pulse_generator
(
  input  wire       clock,
  input  wire       rst_n,
  input  wire       start,
  input  wire       use_hundred,
  input  wire [2:0] width,
  output reg        ten_level,
  output reg  [1:0] hundred_sym
);

  reg  [2:0] count_reg;
  reg        negative_next_reg;
  reg  [2:0] length;

  // Link pulse lengths round up to whole clocks; the counter needs only three bits.
  localparam [31:0] SHORT_CYCLES = `TEN_SHORT_CYCLES;
  localparam [31:0] LONG_CYCLES  = `TEN_LONG_CYCLES;

  always @*
  begin
    if (width == 3'h0)
      length = 3'h0;
    else if (use_hundred)
      length = width;
    else if (width >= `TEN_LONG_MIN_WIDTH)
      length = LONG_CYCLES[2:0];
    else
      length = SHORT_CYCLES[2:0];
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg         <= 3'h0;
      negative_next_reg <= 1'b0;
      ten_level         <= 1'b0;
      hundred_sym       <= `SYM_IDLE;
    end
    else if (start && length != 3'h0)
    begin
      count_reg <= length - 3'h1;
      if (use_hundred)
      begin
        // Alternating polarity keeps the line free of a net DC shift.
        hundred_sym       <= negative_next_reg ? `SYM_NEG : `SYM_POS;
        negative_next_reg <= ~negative_next_reg;
        ten_level         <= 1'b0;
      end
      else
      begin
        ten_level   <= 1'b1;
        hundred_sym <= `SYM_IDLE;
      end
    end
    else if (count_reg != 3'h0)
      count_reg <= count_reg - 3'h1;
    else
    begin
      ten_level   <= 1'b0;
      hundred_sym <= `SYM_IDLE;
    end
  end

endmodule // test_pulse_generator
`default_nettype wire
